// [crf_regfile.sv]
// core register file: general registers, control registers and dsp accumulator
//
// Notes on behaviour
// - sixteen general registers, any usable as data or address operand.
// - general register zero reads and writes the active stack pointer.
// - status word select bit picks user or interrupt stack pointer.
// - vector table base register holds relocatable vector table start.
// - program counter holds address of instruction being executed.
// - taking a fast interrupt copies program counter to its backup.
// - taking a fast interrupt copies status word to its backup, same layout.
// - fast interrupt branches to address in fast interrupt vector.
// - accumulator is 64 bits; multiply instructions overwrite it whole.
// - high write loads bits 63..32, low write loads bits 31..0.
// - high read returns bits 63..32, middle read returns bits 47..16.
// - address registers span the full linear 32-bit byte space.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "crf_cfg.svh"

module crf_regfile (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CRF_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// general register ports from the execution unit
	input wire logic gpr_we,
	input wire logic [3:0] gpr_waddr,
	input wire logic [31:0] gpr_wdata,
	input wire logic [3:0] gpr_raddr,
	output logic [31:0] gpr_rdata,
	// program counter and status word updates
	input wire logic pc_we,
	input wire logic [31:0] pc_wdata,
	input wire logic status_we,
	input wire logic [31:0] status_wdata,
	// fast interrupt sequencing
	input wire logic fast_irq_take,
	input wire logic fast_irq_return,
	// accumulator ports
	input wire logic multiply_result_we,
	input wire logic [63:0] multiply_result,
	input wire logic acc_high_write,
	input wire logic acc_low_write,
	input wire logic [31:0] acc_wdata,
	output logic [31:0] acc_high_read,
	output logic [31:0] acc_middle_read,
	// control register views
	output logic [31:0] pc,
	output logic [31:0] status_word,
	output logic [31:0] vector_table_base
);

	crf_pkg::crf_state_s s;
	crf_pkg::crf_state_s next_s;
	logic bus_setup;
	logic bus_write;
	logic [32:0] bus_rd;

	////////////////////////////////////////////////////////////////////////
	// helper functions

	// read a general register; index zero is the selected stack pointer
	function automatic logic [31:0] get_gpr(input crf_pkg::crf_state_s st, input logic [3:0] idx);
		logic [31:0] v;
		v = st.gpr[idx];
		if (idx == 4'h0) begin
			v = st.status_word[`CRF_STW_U] ? st.user_stack_ptr : st.irq_stack_ptr;
		end
		return v;
	endfunction

	// write a general register; u is the stack select in force this cycle
	function automatic crf_pkg::crf_state_s put_gpr(input crf_pkg::crf_state_s st, input logic u,
		input logic [3:0] idx, input logic [31:0] d);
		crf_pkg::crf_state_s r;
		r = st;
		if (idx != 4'h0) begin
			r.gpr[idx] = d;
		end else if (u) begin
			r.user_stack_ptr = d;
		end else begin
			r.irq_stack_ptr = d;
		end
		return r;
	endfunction

	// bus read decode: bit 32 flags an unmapped or misaligned address
	function automatic logic [32:0] bus_read(input crf_pkg::crf_state_s st, input logic [`CRF_AW-1:0] a);
		logic [32:0] v;
		v = {1'b0, `CRF_RST_WORD};
		case (a)
			`CRF_OFF_VTB: v[31:0] = st.vector_table_base;
			`CRF_OFF_FIV: v[31:0] = st.fast_irq_vector;
			`CRF_OFF_ISTK: v[31:0] = st.irq_stack_ptr;
			`CRF_OFF_USTK: v[31:0] = st.user_stack_ptr;
			`CRF_OFF_PC: v[31:0] = st.pc;
			`CRF_OFF_STW: v[31:0] = st.status_word;
			`CRF_OFF_PCBK: v[31:0] = st.fast_irq_pc_backup;
			`CRF_OFF_BSW: v[31:0] = st.fast_irq_status_backup;
			`CRF_OFF_ALO: v[31:0] = st.dsp_accumulator[31:0];
			`CRF_OFF_AHI: v[31:0] = st.dsp_accumulator[63:32];
			`CRF_OFF_AMI: v[31:0] = st.dsp_accumulator[47:16];
			default: begin
				if (a[11:6] == 6'(`CRF_OFF_GPR >> 6) && a[1:0] == 2'b00) begin
					v[31:0] = get_gpr(st, a[5:2]);
				end else begin
					v[32] = 1'b1;
				end
			end
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb phase decode

	// setup cycle samples read data; write lands at the access edge
	assign bus_setup = psel & ~penable;
	assign bus_write = psel & penable & pwrite & s.pready & ~s.pslverr;
	assign bus_rd = bus_read(s, paddr);

	////////////////////////////////////////////////////////////////////////
	// next state

	// bus writes first, core updates after so the core wins a collision
	always_comb begin
		next_s = s;
		next_s.pready = bus_setup;
		if (bus_setup) begin
			next_s.prdata = bus_rd[31:0];
			next_s.pslverr = bus_rd[32];
		end
		if (bus_write) begin
			case (paddr)
				`CRF_OFF_VTB: next_s.vector_table_base = pwdata;
				`CRF_OFF_FIV: next_s.fast_irq_vector = pwdata;
				`CRF_OFF_ISTK: next_s.irq_stack_ptr = pwdata;
				`CRF_OFF_USTK: next_s.user_stack_ptr = pwdata;
				`CRF_OFF_STW: next_s.status_word = pwdata;
				`CRF_OFF_ALO: next_s.dsp_accumulator[31:0] = pwdata;
				`CRF_OFF_AHI: next_s.dsp_accumulator[63:32] = pwdata;
				`CRF_OFF_GPR, `CRF_OFF_GPR + 12'h004, `CRF_OFF_GPR + 12'h008, `CRF_OFF_GPR + 12'h00c,
				`CRF_OFF_GPR + 12'h010, `CRF_OFF_GPR + 12'h014, `CRF_OFF_GPR + 12'h018, `CRF_OFF_GPR + 12'h01c,
				`CRF_OFF_GPR + 12'h020, `CRF_OFF_GPR + 12'h024, `CRF_OFF_GPR + 12'h028, `CRF_OFF_GPR + 12'h02c,
				`CRF_OFF_GPR + 12'h030, `CRF_OFF_GPR + 12'h034, `CRF_OFF_GPR + 12'h038, `CRF_OFF_GPR + 12'h03c: begin
					next_s = put_gpr(next_s, s.status_word[`CRF_STW_U], paddr[5:2], pwdata);
				end
				default: next_s.pslverr = s.pslverr; // read-only words ignore writes
			endcase
		end
		// core general register write, full 32-bit address values
		if (gpr_we) begin
			next_s = put_gpr(next_s, s.status_word[`CRF_STW_U], gpr_waddr, gpr_wdata);
		end
		if (status_we) begin
			next_s.status_word = status_wdata;
		end
		if (pc_we) begin
			next_s.pc = pc_wdata;
		end
		// return from fast interrupt undoes the save
		if (fast_irq_return) begin
			next_s.pc = s.fast_irq_pc_backup;
			next_s.status_word = s.fast_irq_status_backup;
		end
		// taking a fast interrupt: save and branch, wins over every other pc update
		if (fast_irq_take) begin
			next_s.fast_irq_pc_backup = s.pc;
			next_s.fast_irq_status_backup = s.status_word;
			next_s.pc = s.fast_irq_vector;
		end
		// accumulator half writes, then whole-result overwrite
		if (acc_low_write) begin
			next_s.dsp_accumulator[31:0] = acc_wdata;
		end
		if (acc_high_write) begin
			next_s.dsp_accumulator[63:32] = acc_wdata;
		end
		if (multiply_result_we) begin
			next_s.dsp_accumulator = multiply_result;
		end
		// registered read ports
		next_s.gpr_rdata = get_gpr(s, gpr_raddr);
		next_s.acc_high_rdata = s.dsp_accumulator[63:32];
		next_s.acc_middle_rdata = s.dsp_accumulator[47:16];
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// all state resets to zero; stack select starts on interrupt stack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// every output is a field of the state register
	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign gpr_rdata = s.gpr_rdata;
	assign acc_high_read = s.acc_high_rdata;
	assign acc_middle_read = s.acc_middle_rdata;
	assign pc = s.pc;
	assign status_word = s.status_word;
	assign vector_table_base = s.vector_table_base;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_gpr_write;
		gpr_we && gpr_waddr != 4'h0 |=> s.gpr[$past(gpr_waddr)] == $past(gpr_wdata);
	endproperty
	a_gpr_write: assert property (p_gpr_write) else $error("general register write lost");

	property p_sp_user;
		gpr_we && gpr_waddr == 4'h0 && s.status_word[`CRF_STW_U] |=> s.user_stack_ptr == $past(gpr_wdata);
	endproperty
	a_sp_user: assert property (p_sp_user) else $error("user stack pointer not written");

	property p_sp_irq;
		gpr_we && gpr_waddr == 4'h0 && !s.status_word[`CRF_STW_U] |=> s.irq_stack_ptr == $past(gpr_wdata);
	endproperty
	a_sp_irq: assert property (p_sp_irq) else $error("interrupt stack pointer not written");

	property p_fint_pc;
		fast_irq_take |=> s.fast_irq_pc_backup == $past(s.pc);
	endproperty
	a_fint_pc: assert property (p_fint_pc) else $error("pc not saved on fast interrupt");

	property p_fint_stw;
		fast_irq_take |=> s.fast_irq_status_backup == $past(s.status_word);
	endproperty
	a_fint_stw: assert property (p_fint_stw) else $error("status not saved on fast interrupt");

	property p_fint_vec;
		fast_irq_take |=> pc == $past(s.fast_irq_vector);
	endproperty
	a_fint_vec: assert property (p_fint_vec) else $error("no branch to fast vector");

	property p_fint_ret;
		fast_irq_return && !fast_irq_take |=> pc == $past(s.fast_irq_pc_backup)
			&& status_word == $past(s.fast_irq_status_backup);
	endproperty
	a_fint_ret: assert property (p_fint_ret) else $error("fast return did not restore");

	property p_pc_load;
		pc_we && !fast_irq_return && !fast_irq_take |=> pc == $past(pc_wdata);
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("program counter load lost");

	property p_vtb_write;
		psel && penable && pwrite && pready && !pslverr && paddr == `CRF_OFF_VTB
			|=> vector_table_base == $past(pwdata);
	endproperty
	a_vtb_write: assert property (p_vtb_write) else $error("vector table base write lost");

	property p_acc_mul;
		multiply_result_we |=> s.dsp_accumulator == $past(multiply_result)
			##1 acc_high_read == $past(multiply_result[63:32], 2);
	endproperty
	a_acc_mul: assert property (p_acc_mul) else $error("multiply did not overwrite accumulator");

	property p_acc_half;
		acc_high_write && !acc_low_write && !multiply_result_we |=> s.dsp_accumulator[63:32] == $past(acc_wdata)
			&& s.dsp_accumulator[31:0] == $past(s.dsp_accumulator[31:0]);
	endproperty
	a_acc_half: assert property (p_acc_half) else $error("accumulator high write wrong");

	property p_acc_mid;
		acc_low_write && !acc_high_write && !multiply_result_we
			|=> ##1 acc_middle_read[15:0] == $past(acc_wdata[31:16], 2);
	endproperty
	a_acc_mid: assert property (p_acc_mid) else $error("middle read misaligned");

	property p_apb_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one access cycle");

	property p_apb_err;
		psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("misaligned access not flagged");

	c_fint: cover property (fast_irq_take ##1 fast_irq_return);
	c_sp_user: cover property (gpr_we && gpr_waddr == 4'h0 && s.status_word[`CRF_STW_U]);
	c_apb_wr: cover property (psel && penable && pwrite && pready);
	c_mul: cover property (multiply_result_we ##1 acc_high_write);

endmodule

// [crf_cfg.svh]
// offsets, field positions, reset values and widths of the core register file
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH

// data and address widths
`define CRF_DW 32
`define CRF_AW 12

// apb word offsets (byte addresses)
`define CRF_OFF_VTB 12'h000
`define CRF_OFF_FIV 12'h004
`define CRF_OFF_ISTK 12'h008
`define CRF_OFF_USTK 12'h00c
`define CRF_OFF_PC 12'h010
`define CRF_OFF_STW 12'h014
`define CRF_OFF_PCBK 12'h018
`define CRF_OFF_BSW 12'h01c
`define CRF_OFF_ALO 12'h020
`define CRF_OFF_AHI 12'h024
`define CRF_OFF_AMI 12'h028
`define CRF_OFF_GPR 12'h040

// status word field: stack pointer select (1 = user stack)
`define CRF_STW_U 17

// reset values
`define CRF_RST_WORD 32'h0000_0000
`define CRF_RST_ACC 64'h0000_0000_0000_0000

`endif

// [crf_pkg.sv]
// types of the core register file
package crf_pkg;

	typedef logic [31:0] crf_word_t;

	// whole state of the register file, registered as one
	typedef struct packed {
		logic [15:0][31:0] gpr;
		crf_word_t irq_stack_ptr;
		crf_word_t user_stack_ptr;
		crf_word_t vector_table_base;
		crf_word_t pc;
		crf_word_t status_word;
		crf_word_t fast_irq_pc_backup;
		crf_word_t fast_irq_status_backup;
		crf_word_t fast_irq_vector;
		logic [63:0] dsp_accumulator;
		crf_word_t gpr_rdata;
		crf_word_t acc_high_rdata;
		crf_word_t acc_middle_rdata;
		crf_word_t prdata;
		logic pready;
		logic pslverr;
	} crf_state_s;

endpackage

// [crf_core_model.sv]
// behavioural model of the execution unit that drives the core-side ports
`timescale 1ns/1ps
module crf_core_model (
	// clock
	input wire logic pclk,
	// register and control updates
	output logic gpr_we,
	output logic [3:0] gpr_waddr,
	output logic [31:0] gpr_wdata,
	output logic pc_we,
	output logic [31:0] pc_wdata,
	output logic status_we,
	output logic [31:0] status_wdata,
	// fast interrupt sequencing
	output logic fast_irq_take,
	output logic fast_irq_return,
	// accumulator updates
	output logic multiply_result_we,
	output logic [63:0] multiply_result,
	output logic acc_high_write,
	output logic acc_low_write,
	output logic [31:0] acc_wdata
);
	logic [63:0] dq;
	logic [7:0] stb;

	// one shared data bus fans out to every write port
	assign {gpr_we, pc_we, status_we, fast_irq_take} = stb[7:4];
	assign {fast_irq_return, multiply_result_we, acc_high_write, acc_low_write} = stb[3:0];
	assign gpr_wdata = dq[31:0];
	assign pc_wdata = dq[31:0];
	assign status_wdata = dq[31:0];
	assign acc_wdata = dq[31:0];
	assign multiply_result = dq;

	// idle at time zero
	initial begin
		stb = 8'h00;
		dq = 64'h0;
		gpr_waddr = 4'h0;
	end

	// one-cycle strobe: k 0 gpr, 1 pc, 2 status, 3 take, 4 return, 5 multiply, 6 high, 7 low
	task automatic op(input logic [2:0] k, input logic [3:0] a, input logic [63:0] d);
		@(posedge pclk);
		stb <= 8'h80 >> k;
		gpr_waddr <= a;
		dq <= (k == 3'h0 && a == 4'h0) ? {d[63:2], 2'b00} : d; // stack pointer kept word aligned
		@(posedge pclk);
		stb <= 8'h00;
		dq <= ~dq; // released bus shows no stale value
	endtask
endmodule

// [test_cpu_register_file_fast_irq.sv]
// self-checking bench for the core register file
`timescale 1ns/1ps
`include "crf_cfg.svh"
module test_cpu_register_file_fast_irq;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, gpr_wdata, gpr_rdata, pc_wdata, status_wdata, acc_wdata, rd;
	logic [31:0] acc_high_read, acc_middle_read, pc, status_word, vector_table_base;
	logic [3:0] gpr_waddr, gpr_raddr;
	logic [63:0] multiply_result;
	logic gpr_we, pc_we, status_we, fast_irq_take, fast_irq_return;
	logic multiply_result_we, acc_high_write, acc_low_write;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;

	// design and the execution-unit model
	crf_regfile crf_regfile_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .gpr_we, .gpr_waddr, .gpr_wdata, .gpr_raddr, .gpr_rdata, .pc_we, .pc_wdata, .status_we,
		.status_wdata, .fast_irq_take, .fast_irq_return, .multiply_result_we, .multiply_result, .acc_high_write,
		.acc_low_write, .acc_wdata, .acc_high_read, .acc_middle_read, .pc, .status_word, .vector_table_base);
	crf_core_model crf_core_model_i (.pclk, .gpr_we, .gpr_waddr, .gpr_wdata, .pc_we, .pc_wdata, .status_we,
		.status_wdata, .fast_irq_take, .fast_irq_return, .multiply_result_we, .multiply_result, .acc_high_write,
		.acc_low_write, .acc_wdata);

	// 250 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// cut a hung run short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; read data and error land in rd and er
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask

	// core operation, then let the result reach the read ports
	task automatic co(input logic [2:0] k, input logic [3:0] a, input logic [63:0] d);
		crf_core_model_i.op(k, a, d);
		repeat (2) @(posedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		gpr_raddr = 4'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// vector table base reaches the top of the byte space
		apb(1'b1, `CRF_OFF_VTB, 32'hffff_fffc);
		rc(`CRF_OFF_VTB, 32'hffff_fffc);
		chk(vector_table_base, 32'hffff_fffc);
		// general registers one to fifteen each keep their own value on both read paths
		for (int n = 1; n < 16; n++) begin
			co(3'h0, 4'(n), 32'h1111_1111 * n);
		end
		for (int n = 1; n < 16; n++) begin
			gpr_raddr <= 4'(n);
			rc(12'(`CRF_OFF_GPR + 4 * n), 32'h1111_1111 * n);
			chk(gpr_rdata, 32'h1111_1111 * n);
		end
		// register zero follows the stack select bit
		apb(1'b1, `CRF_OFF_ISTK, 32'h0000_0100);
		apb(1'b1, `CRF_OFF_USTK, 32'h0000_0200);
		rc(`CRF_OFF_GPR, 32'h0000_0100);
		apb(1'b1, `CRF_OFF_STW, 32'h1 << `CRF_STW_U);
		rc(`CRF_OFF_GPR, 32'h0000_0200);
		co(3'h0, 4'h0, 64'h0000_0300);
		rc(`CRF_OFF_USTK, 32'h0000_0300);
		rc(`CRF_OFF_ISTK, 32'h0000_0100);
		// fast interrupt saves, branches and restores
		apb(1'b1, `CRF_OFF_FIV, 32'h8000_0040);
		co(3'h1, 4'h0, 64'h0000_1234);
		chk(pc, 32'h0000_1234);
		co(3'h2, 4'h0, 64'h0002_0005);
		co(3'h3, 4'h0, 64'h0);
		chk(pc, 32'h8000_0040);
		rc(`CRF_OFF_PCBK, 32'h0000_1234);
		rc(`CRF_OFF_BSW, 32'h0002_0005);
		co(3'h2, 4'h0, 64'h0);
		co(3'h4, 4'h0, 64'h0);
		chk(pc, 32'h0000_1234);
		chk(status_word, 32'h0002_0005);
		// accumulator overwrite, half writes and views
		co(3'h5, 4'h0, 64'h0123_4567_89ab_cdef);
		chk(acc_high_read, 32'h0123_4567);
		chk(acc_middle_read, 32'h4567_89ab);
		rc(`CRF_OFF_ALO, 32'h89ab_cdef);
		co(3'h7, 4'h0, 64'hffff_0000);
		co(3'h6, 4'h0, 64'h0000_ffff);
		chk(acc_middle_read, 32'hffff_ffff);
		rc(`CRF_OFF_AHI, 32'h0000_ffff);
		rc(`CRF_OFF_ALO, 32'hffff_0000);
		co(3'h5, 4'h0, 64'h0);
		chk(acc_middle_read, 32'h0);
		// read-only and unmapped places
		apb(1'b1, `CRF_OFF_PC, 32'h5555_5555);
		chk(er, 1'b0);
		rc(`CRF_OFF_PC, 32'h0000_1234);
		apb(1'b0, 12'h100, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, 12'h002, 32'h0);
		chk(er, 1'b1);
		print_verdict();
	end
endmodule
